// ===== design/bsct_pkg.sv
/*
 * shared constants and pin bundles for the burst-of-two sram core.
 * assumes one core clock, where alternate edges stand for the K and K# edges.
 */
package bsct_pkg;
    // ************************************************************
    // organisation
    // ************************************************************
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int DATA_W = LANE_W * LANES;
    localparam int ADDR_W = 20;
    localparam int BEATS = 2;
    localparam int WORDS = (1 << ADDR_W) * BEATS;

    // ************************************************************
    // timing in core cycles (one core cycle is half a K period)
    // ************************************************************
    localparam int RD_STAGES = 4;
    localparam int RD_BEAT0_STAGE = 2;
    localparam int RD_BEAT1_STAGE = 3;
    localparam logic K_EDGE = 1'b0;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [1:0] RST_SYNC_INIT = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 20'h0_0000;
    localparam logic [LANES-1:0] MASK_RST = 4'h0;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic [LANES-1:0] lane_write_enable_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] d;
    } bsct_pin_in_t;

    typedef struct packed {
        logic [DATA_W-1:0] q;
        logic q_oe;
    } bsct_pin_out_t;

    localparam bsct_pin_in_t PIN_IN_IDLE = '{rd_n: 1'b1, wr_n: 1'b1,
        lane_write_enable_n: 4'hf, addr: 20'h0_0000, d: 36'h0_0000_0000};
endpackage : bsct_pkg

// ===== design/bsct_pin_sync.sv
/*
 * two-flop synchroniser for the sram pin bundle.
 * assumes pins change outside the core clock's timing; resets to an idle bundle.
 */
`timescale 1ns/100ps
`default_nettype none
module bsct_pin_sync (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire bsct_pkg::bsct_pin_in_t i_pins,
    output bsct_pkg::bsct_pin_in_t o_pins
);
    bsct_pkg::bsct_pin_in_t meta;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta <= bsct_pkg::PIN_IN_IDLE;
            o_pins <= bsct_pkg::PIN_IN_IDLE;
        end else begin
            meta <= i_pins;
            o_pins <= meta;
        end
    end
endmodule : bsct_pin_sync
`default_nettype wire

// ===== design/bsct_sram_core.sv
/*
 * command, beat and lane-write logic of a burst-of-two ddr sram, plus its array.
 * assumes the controller keeps the alternate-edge spacing and drains before
 * stopping the clock; even core cycles (o_k_phase low) stand for K edges.
 */
// What this block does
// - reference: read requested on one K edge, write on the next.
// - both selects high on a K edge: idle cycle, no output driven.
// - every operation is one address and exactly two beats.
// - read select low on a K edge starts a read.
// - write select low on a K edge starts a write.
// - same-type request on the very next K edge is discarded.
// - both selects low after an idle cycle: read only, write dropped.
// - wide organisation: four lane enables per beat; all high aborts beat.
// - writes wait in a buffer; reads of that address return buffered data.
`timescale 1ns/100ps
`default_nettype none
module bsct_sram_core (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire bsct_pkg::bsct_pin_in_t i_pins,
    output bsct_pkg::bsct_pin_out_t o_pins,
    output logic o_k_phase
);
    // ************************************************************
    // reset release and pin capture
    // ************************************************************
    logic [1:0] rst_sync;
    logic rstn;
    bsct_pkg::bsct_pin_in_t sp;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync <= bsct_pkg::RST_SYNC_INIT;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rstn = rst_sync[1];

    bsct_pin_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(rstn),
        .i_pins(i_pins),
        .o_pins(sp)
    );

    // the sync delay is two cycles, so a pin driven in a K cycle arrives in one
    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            o_k_phase <= bsct_pkg::K_EDGE;
        end else begin
            o_k_phase <= ~o_k_phase;
        end
    end

    // ************************************************************
    // command acceptance
    // ************************************************************
    logic k_edge;
    logic rd_req;
    logic wr_req;
    logic idle;
    logic rd_acc;
    logic wr_acc;
    logic rd_last;
    logic wr_last;
    logic idle_last;

    assign k_edge = (o_k_phase == bsct_pkg::K_EDGE);
    assign rd_req = k_edge && !sp.rd_n;
    assign wr_req = k_edge && !sp.wr_n;
    assign idle = k_edge && sp.rd_n && sp.wr_n;
    assign rd_acc = rd_req && !rd_last;
    assign wr_acc = wr_req && !wr_last && !(rd_req && idle_last);

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_last <= 1'b0;
            wr_last <= 1'b0;
            idle_last <= 1'b0;
        end else if (k_edge) begin
            rd_last <= rd_acc;
            wr_last <= wr_acc;
            idle_last <= idle;
        end
    end

    // ************************************************************
    // write staging and buffer
    // ************************************************************
    logic wr_b1;
    logic [bsct_pkg::DATA_W-1:0] stg_d0;
    logic [bsct_pkg::LANES-1:0] stg_m0;
    logic buf_vld;
    logic [bsct_pkg::ADDR_W-1:0] buf_addr;
    logic [bsct_pkg::DATA_W-1:0] buf_d0;
    logic [bsct_pkg::DATA_W-1:0] buf_d1;
    logic [bsct_pkg::LANES-1:0] buf_m0;
    logic [bsct_pkg::LANES-1:0] buf_m1;
    logic commit;

    // the old burst is committed in the very cycle the new one replaces it,
    // so a read looking up the array that cycle still finds it in the buffer
    assign commit = wr_b1 && buf_vld;

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_b1 <= 1'b0;
            stg_d0 <= bsct_pkg::DATA_RST;
            stg_m0 <= bsct_pkg::MASK_RST;
        end else begin
            wr_b1 <= wr_acc;
            if (wr_acc) begin
                stg_d0 <= sp.d;
                stg_m0 <= ~sp.lane_write_enable_n;
            end
        end
    end

    // write address arrives with the second beat, one cycle (half a K period) after the command
    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            buf_vld <= 1'b0;
            buf_addr <= bsct_pkg::ADDR_RST;
            buf_d0 <= bsct_pkg::DATA_RST;
            buf_d1 <= bsct_pkg::DATA_RST;
            buf_m0 <= bsct_pkg::MASK_RST;
            buf_m1 <= bsct_pkg::MASK_RST;
        end else if (wr_b1) begin
            buf_vld <= 1'b1;
            buf_addr <= sp.addr;
            buf_d0 <= stg_d0;
            buf_m0 <= stg_m0;
            buf_d1 <= sp.d;
            buf_m1 <= ~sp.lane_write_enable_n;
        end
    end

    // ************************************************************
    // array
    // ************************************************************
    logic [bsct_pkg::DATA_W-1:0] mem [bsct_pkg::WORDS];

    // a beat with every lane enable high writes nothing
    always_ff @(posedge i_core_clk) begin
        if (commit) begin
            for (int l = 0; l < bsct_pkg::LANES; l++) begin
                if (buf_m0[l]) begin
                    mem[{buf_addr, 1'b0}][l*bsct_pkg::LANE_W +: bsct_pkg::LANE_W]
                        <= buf_d0[l*bsct_pkg::LANE_W +: bsct_pkg::LANE_W];
                end
                if (buf_m1[l]) begin
                    mem[{buf_addr, 1'b1}][l*bsct_pkg::LANE_W +: bsct_pkg::LANE_W]
                        <= buf_d1[l*bsct_pkg::LANE_W +: bsct_pkg::LANE_W];
                end
            end
        end
    end

    function automatic logic [bsct_pkg::DATA_W-1:0] merge_lanes(
        input logic [bsct_pkg::DATA_W-1:0] arr,
        input logic [bsct_pkg::DATA_W-1:0] bufd,
        input logic [bsct_pkg::LANES-1:0] mask,
        input logic hit
    );
        logic [bsct_pkg::DATA_W-1:0] res;
        res = arr;
        for (int l = 0; l < bsct_pkg::LANES; l++) begin
            if (hit && mask[l]) begin
                res[l*bsct_pkg::LANE_W +: bsct_pkg::LANE_W] =
                    bufd[l*bsct_pkg::LANE_W +: bsct_pkg::LANE_W];
            end
        end
        return res;
    endfunction : merge_lanes

    // ************************************************************
    // read pipeline
    // ************************************************************
    logic [bsct_pkg::RD_STAGES-1:0] rd_vld;
    logic [bsct_pkg::ADDR_W-1:0] rd_addr [bsct_pkg::RD_STAGES];
    logic [bsct_pkg::ADDR_W-1:0] a0;
    logic [bsct_pkg::ADDR_W-1:0] a1;

    assign a0 = rd_addr[bsct_pkg::RD_BEAT0_STAGE];
    assign a1 = rd_addr[bsct_pkg::RD_BEAT1_STAGE];

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            rd_vld <= '0;
            for (int s = 0; s < bsct_pkg::RD_STAGES; s++) begin
                rd_addr[s] <= bsct_pkg::ADDR_RST;
            end
        end else begin
            rd_vld <= {rd_vld[bsct_pkg::RD_STAGES-2:0], rd_acc};
            rd_addr[0] <= sp.addr;
            for (int s = 1; s < bsct_pkg::RD_STAGES; s++) begin
                rd_addr[s] <= rd_addr[s-1];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rstn) begin
        if (!rstn) begin
            o_pins.q <= bsct_pkg::DATA_RST;
            o_pins.q_oe <= 1'b0;
        end else if (rd_vld[bsct_pkg::RD_BEAT0_STAGE]) begin
            // a write on the next K edge is still in staging here; without this
            // layer beat one would be stale while beat two is already new
            o_pins.q <= merge_lanes(merge_lanes(mem[{a0, 1'b0}], buf_d0, buf_m0,
                buf_vld && buf_addr == a0), stg_d0, stg_m0,
                wr_b1 && sp.addr == a0);
            o_pins.q_oe <= 1'b1;
        end else if (rd_vld[bsct_pkg::RD_BEAT1_STAGE]) begin
            o_pins.q <= merge_lanes(mem[{a1, 1'b1}], buf_d1, buf_m1,
                buf_vld && buf_addr == a1);
            o_pins.q_oe <= 1'b1;
        end else begin
            o_pins.q <= bsct_pkg::DATA_RST;
            o_pins.q_oe <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    rd_beat_win_a: assert property (@(posedge i_core_clk) disable iff (!rstn)
        rd_acc |-> ##4 o_pins.q_oe ##1 o_pins.q_oe ##1 !o_pins.q_oe)
        else $error("read beats not at four and five cycles");
    idle_quiet_a: assert property (@(posedge i_core_clk) disable iff (!rstn)
        idle && rd_vld == '0 |-> !rd_acc && !wr_acc ##4 !o_pins.q_oe)
        else $error("idle cycle produced an operation");
    rd_start_a: assert property (@(posedge i_core_clk) disable iff (!rstn)
        rd_req && !rd_last |=> rd_vld[0])
        else $error("read not started");
    wr_start_a: assert property (@(posedge i_core_clk) disable iff (!rstn)
        wr_req && !wr_last && !idle_last |=> wr_b1 ##1 buf_vld)
        else $error("write not started");
    rd_spacing_a: assert property (@(posedge i_core_clk) disable iff (!rstn)
        rd_acc |-> ##2 !rd_acc)
        else $error("back to back read accepted");
    wr_spacing_a: assert property (@(posedge i_core_clk) disable iff (!rstn)
        wr_acc |-> ##2 !wr_acc)
        else $error("back to back write accepted");
    both_after_idle_a: assert property (@(posedge i_core_clk) disable iff (!rstn)
        idle_last && rd_req && wr_req |-> rd_acc && !wr_acc)
        else $error("write kept after idle cycle");
    buf_load_a: assert property (@(posedge i_core_clk) disable iff (!rstn)
        wr_acc |=> buf_m0 == $past(buf_m0) ##1 buf_vld && buf_d0 == $past(sp.d, 2))
        else $error("write beat one not buffered");
    lanes_seen_a: assert property (@(posedge i_core_clk) disable iff (!rstn)
        wr_acc |=> stg_m0 == ~$past(sp.lane_write_enable_n))
        else $error("lane enables not sampled on the K edge");
endmodule : bsct_sram_core
`default_nettype wire

// ===== bench/bsct_ctl_model.sv
/*
 * controller model that drives the sram pins, one burst per call.
 * assumes the core's phase output marks K cycles; drives 1 ns after each edge.
 */
`timescale 1ns/100ps
`default_nettype none
module bsct_ctl_model (
    input wire logic i_core_clk,
    input wire logic i_k_phase,
    output var bsct_pkg::bsct_pin_in_t o_pins
);
    int stalls = 0;
    // the clock never stops here, so nothing is left pending
    initial o_pins = bsct_pkg::PIN_IN_IDLE;
    // ************************************************************
    // pin tasks
    // ************************************************************
    task automatic cmd(input logic rd, input logic wr, input logic [19:0] ra,
            input logic [19:0] wa, input logic [35:0] d0, input logic [3:0] e0,
            input logic [35:0] d1, input logic [3:0] e1);
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            #1;
            n++;
        end while (i_k_phase !== 1'h0 && n < 4);
        if (i_k_phase !== 1'h0) stalls++;
        o_pins = '{rd_n: ~rd, wr_n: ~wr, lane_write_enable_n: e0, addr: ra, d: d0};
        @(posedge i_core_clk);
        #1;
        o_pins = '{rd_n: 1'h1, wr_n: 1'h1, lane_write_enable_n: e1, addr: wa, d: d1};
    endtask : cmd
    // released lines show the inverse, so a late sample cannot match by luck
    task automatic idle();
        @(posedge i_core_clk);
        #1;
        o_pins = '{rd_n: 1'h1, wr_n: 1'h1, lane_write_enable_n: 4'hf,
            addr: ~o_pins.addr, d: ~o_pins.d};
    endtask : idle
endmodule : bsct_ctl_model
`default_nettype wire

// ===== bench/testbench.sv
/*
 * self-checking bench for the burst-of-two sram core.
 * assumes the controller model beside it and the core's stated latencies.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [19:0] A = 20'h0_0011;
    localparam logic [19:0] B = 20'h0_0022;
    localparam logic [19:0] C = 20'h0_0033;
    localparam logic [19:0] E = 20'h0_0044;
    logic clk;
    logic rstn;
    bsct_pkg::bsct_pin_in_t pins;
    bsct_pkg::bsct_pin_out_t qo;
    logic kph;
    int fails = 0;
    int compares = 0;
    logic [35:0] mem [logic [20:0]];
    bsct_sram_core dut (.i_core_clk(clk), .i_resetn(rstn), .i_pins(pins),
        .o_pins(qo), .o_k_phase(kph));
    bsct_ctl_model m (.i_core_clk(clk), .i_k_phase(kph), .o_pins(pins));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [35:0] p(input logic [8:0] x);
        return {4{x}};
    endfunction : p
    task automatic cmp(input logic [36:0] got, input logic [36:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic upd(input logic [19:0] a, input logic [35:0] d0, input logic [3:0] e0,
            input logic [35:0] d1, input logic [3:0] e1);
        logic [35:0] w0;
        logic [35:0] w1;
        w0 = mem.exists({a, 1'h0}) ? mem[{a, 1'h0}] : 36'h0;
        w1 = mem.exists({a, 1'h1}) ? mem[{a, 1'h1}] : 36'h0;
        for (int i = 0; i < 4; i++) begin
            if (!e0[i]) w0[i*9 +: 9] = d0[i*9 +: 9];
            if (!e1[i]) w1[i*9 +: 9] = d1[i*9 +: 9];
        end
        mem[{a, 1'h0}] = w0;
        mem[{a, 1'h1}] = w1;
    endtask : upd
    task automatic wr(input logic [19:0] a, input logic [35:0] d0, input logic [3:0] e0,
            input logic [35:0] d1, input logic [3:0] e1);
        m.cmd(1'h0, 1'h1, ~a, a, d0, e0, d1, e1);
        m.idle();
        upd(a, d0, e0, d1, e1);
    endtask : wr
    // beats at cycles 6 and 7 after the command, then two quiet cycles
    task automatic chk(input logic [19:0] a, input logic on);
        logic [36:0] e0;
        logic [36:0] e1;
        e0 = on ? {1'h1, mem[{a, 1'h0}]} : 37'h0;
        e1 = on ? {1'h1, mem[{a, 1'h1}]} : 37'h0;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            #1;
            cmp({qo.q_oe, qo.q}, i == 0 ? e0 : i == 1 ? e1 : 37'h0);
            @(posedge clk);
        end
    endtask : chk
    task automatic rq(input logic [19:0] a);
        m.cmd(1'h1, 1'h0, a, ~a, 36'h0, 4'hf, 36'h0, 4'hf);
    endtask : rq
    task automatic rc(input logic [19:0] a);
        rq(a);
        fork
            chk(a, 1'h1);
        join_none
    endtask : rc
    task automatic rd(input logic [19:0] a);
        rc(a);
        m.idle();
    endtask : rd
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic s_basic();
        wr(A, p(9'h1a5), 4'h0, p(9'h05a), 4'h0);
        rd(A);
        wr(B, p(9'h133), 4'h0, p(9'h0cc), 4'h0);
        rd(A);
        rd(B);
        wait fork;
    endtask : s_basic
    task automatic s_lanes();
        wr(C, p(9'h0ff), 4'h0, p(9'h100), 4'h0);
        for (int i = 0; i < 4; i++) begin
            wr(C, p(9'h011) << i, ~(4'h1 << i), p(9'h022), i == 3 ? 4'hf : ~(4'h8 >> i));
        end
        wr(C, p(9'h033), 4'hc, p(9'h044), 4'hf);
        wr(C, p(9'h055), 4'hf, p(9'h066), 4'hd);
        rd(C);
        wait fork;
    endtask : s_lanes
    task automatic s_idle();
        m.cmd(1'h0, 1'h0, B, B, p(9'h1ff), 4'h0, p(9'h1ff), 4'h0);
        m.idle();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            cmp({qo.q_oe, qo.q}, 37'h0);
        end
        rd(B);
        wait fork;
    endtask : s_idle
    task automatic s_b2b();
        rc(A);
        rq(B);
        m.cmd(1'h0, 1'h1, A, E, p(9'h0e1), 4'h0, p(9'h0e2), 4'h0);
        m.cmd(1'h0, 1'h1, A, E, p(9'h0e3), 4'h0, p(9'h0e4), 4'h0);
        upd(E, p(9'h0e1), 4'h0, p(9'h0e2), 4'h0);
        m.idle();
        wait fork;
        rd(E);
        wait fork;
    endtask : s_b2b
    task automatic s_both();
        m.cmd(1'h1, 1'h1, A, A, p(9'h1e7), 4'h0, p(9'h1e7), 4'h0);
        fork
            chk(A, 1'h1);
        join_none
        m.idle();
        wait fork;
        rd(A);
        wait fork;
    endtask : s_both
    task automatic s_conc();
        rc(A);
        m.cmd(1'h1, 1'h1, A, C, p(9'h0d1), 4'h0, p(9'h0d2), 4'h0);
        upd(C, p(9'h0d1), 4'h0, p(9'h0d2), 4'h0);
        m.idle();
        wait fork;
        rc(B);
        m.cmd(1'h0, 1'h1, A, E, p(9'h0d3), 4'h0, p(9'h0d4), 4'h0);
        upd(E, p(9'h0d3), 4'h0, p(9'h0d4), 4'h0);
        m.idle();
        wait fork;
        rd(C);
        rd(E);
        upd(B, p(9'h0b1), 4'h0, p(9'h0b2), 4'h3);
        rc(B);
        m.cmd(1'h0, 1'h1, A, B, p(9'h0b1), 4'h0, p(9'h0b2), 4'h3);
        m.idle();
        wait fork;
    endtask : s_conc
    task automatic close_out();
        fails += m.stalls;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    initial begin
        rstn = 1'h0;
        repeat (5) @(posedge clk);
        #1;
        cmp({qo.q_oe, qo.q}, 37'h0);
        cmp({36'h0, kph}, 37'h0);
        rstn = 1'h1;
        repeat (6) @(posedge clk);
        s_basic();
        s_lanes();
        s_idle();
        s_b2b();
        s_both();
        s_conc();
        close_out();
    end
endmodule : testbench
`default_nettype wire
